/* File: hw/dor_nvm.sv */
/*
  Image of the user nonvolatile memory: control words and calibration constants.
  Assumes software loads it over the register bus; contents return to defaults at reset.
*/
module dor_nvm
  import dor_pkg::*;
#(
  parameter int DEPTH = NVM_DEPTH,
  parameter int DW = NVM_DW
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write port
  input wire logic we,
  input wire logic [MEM_IW-1:0] widx,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [MEM_IW-1:0] ridx,
  output logic [DW-1:0] rdata,
  // decoded words
  output logic [DW-1:0] ctrl1,
  output logic [DW-1:0] cal
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= (i == 0) ? NVM_CTRL1_RST : NVM_CAL_RST;
    end
    else if (we)
    begin
      mem_q[widx] <= wdata;
    end
  end

  assign rdata = mem_q[ridx];
  assign ctrl1 = mem_q[0];
  assign cal = mem_q[1];
endmodule : dor_nvm

/* File: hw/dor_pkg.sv */
/*
  Shared constants, types and decode helpers of the diagnosis output response block.
  Assumes a single 100 MHz clock and word-aligned AHB-Lite register accesses.
*/
package dor_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_NS = 1000;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;

  // ==========================================================
  // fault sources, bit positions in the fault vector
  localparam int NF = 9;
  localparam int F_OSC = 0;
  localparam int F_WDOG = 1;
  localparam int F_CRC = 2;
  localparam int F_INSTG = 3;
  localparam int F_OUTSTG = 4;
  localparam int F_OTW = 5;
  localparam int F_OTSD = 6;
  localparam int F_OVV = 7;
  localparam int F_REVP = 8;

  // faults that hold the pins released until power-on reset
  localparam logic [NF-1:0] LATCH_ANA_MASK = 9'h057;
  localparam logic [NF-1:0] LATCH_DIG_MASK = 9'h043;
  // faults that release the pins only while present
  localparam logic [NF-1:0] HIZ_ANA_MASK = 9'h188;
  localparam logic [NF-1:0] HIZ_DIG_MASK = 9'h180;
  // faults that raise the error flag of the serial word
  localparam logic [NF-1:0] DIAG_DIG_MASK = 9'h02c;

  // ==========================================================
  // serial word layout and fault codes
  localparam int ANGLE_W = 13;
  localparam int SW_W = 14;
  localparam int SW_ERR = 13;
  localparam logic [1:0] CODE_INSTG = 2'h0;
  localparam logic [1:0] CODE_CRC = 2'h1;
  localparam logic [1:0] CODE_OTW = 2'h2;

  // ==========================================================
  // first control word fields and output modes
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int CNT_LSB = 4;
  localparam int CNT_W = 3;
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_CPL = 3'h1;
  localparam logic [2:0] MODE_INV = 3'h4;
  localparam logic [2:0] MODE_HALF = 3'h5;
  localparam logic [2:0] MODE_CMP = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;

  // ==========================================================
  // memories and register map
  localparam int NVM_DW = 16;
  localparam int MEM_IW = 3;
  localparam int NVM_DEPTH = 8;
  localparam int RAM_DEPTH = 8;
  localparam logic [NVM_DW-1:0] NVM_CTRL1_RST = 16'h0000;
  localparam logic [NVM_DW-1:0] NVM_CAL_RST = 16'h0000;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_NVM_BASE = 8'h40;
  localparam logic [7:0] OFS_RAM_BASE = 8'h80;
  localparam logic [NF-1:0] MASK_RST = 9'h000;

  typedef enum logic [2:0] {REG_STATUS, REG_MASK, REG_STATE, REG_NVM, REG_RAM, REG_NONE} dor_region_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD} dor_bus_t;

  // shared by the read mux and the write strobes
  function automatic dor_region_t dor_region(input logic [7:0] a);
    dor_region_t r;
    r = REG_NONE;
    if (a == OFS_STATUS) r = REG_STATUS;
    else if (a == OFS_MASK) r = REG_MASK;
    else if (a == OFS_STATE) r = REG_STATE;
    else if (a[7:5] == OFS_NVM_BASE[7:5]) r = REG_NVM;
    else if (a[7:5] == OFS_RAM_BASE[7:5]) r = REG_RAM;
    return r;
  endfunction : dor_region
endpackage : dor_pkg

/* File: hw/dor_qual.sv */
/*
  Fault qualifier: a fault counts only after a programmed number of sampled detections.
  Assumes det comes from logic on the same clock and tick is a one-cycle pulse.
*/
module dor_qual
  import dor_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sampling
  input wire logic tick,
  input wire logic det,
  input wire logic [CW-1:0] thr,
  // result
  output logic qual_q
);
  localparam logic [CW-1:0] ONE = 1;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] thr_eff;

  // a zero count means act on the first detection
  assign thr_eff = (thr == '0) ? ONE : thr;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      qual_q <= 1'b0;
    end
    else if (tick)
    begin
      if (!det)
      begin
        cnt_q <= '0;
        qual_q <= 1'b0;
      end
      else
      begin
        if (cnt_q != thr_eff) cnt_q <= cnt_q + ONE;
        qual_q <= (cnt_q >= thr_eff - ONE);
      end
    end
  end
endmodule : dor_qual

/* File: hw/dor_top.sv */
/*
  Diagnosis output response: turns qualified faults into released pins or serial error codes.
  Assumes fault detectors, angle path and serial framer run on clk; arst_n is power-on reset.
*/
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
// How it works
// - analog mode fault releases both output pins instead of driving a level
// - digital mode fault raises the error flag of the serial word
// - with error flag set, a fault code sits in the lowest word bits
// - some faults recover only by power-on reset, others clear themselves
// - a fault acts only after a programmed count of sampled detections
// - mode and count come from control words of the nonvolatile image
// - oscillator, watchdog, analog checksum, output stage, shutdown hold release until reset
// - input stage fault releases pins in analog, flags in digital, self-recovers
// - temperature warning flags only in digital; output stage mismatch acts only analog
// - calibration offset comes from the nonvolatile image; results land in working ram
// - three-bit mode field: 1xx analog variants, 000 and 001 serial
// - error flag set: two low angle bits become code, upper bits stay angle
module dor_top
  import dor_pkg::*;
#(
  parameter logic [ANGLE_W-1:0] CMP_THRESH = 13'h1000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // fault detectors and angle path
  input wire logic [NF-1:0] fault_det,
  input wire logic [ANGLE_W-1:0] angle_in,
  // output pins
  output logic [SW_W-1:0] serial_word,
  output logic error_flag,
  output logic [ANGLE_W-1:0] data_or_analog_out_a,
  output logic data_or_analog_out_a_oe_n,
  output logic [ANGLE_W-1:0] clock_or_analog_out_b,
  output logic clock_or_analog_out_b_oe_n,
  // interrupt
  output logic irq
);
  // ==========================================================
  // declarations
  dor_bus_t bus_st_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [31:0] rd_mux;
  dor_region_t wr_reg;
  logic wr_en;
  logic addr_ok;
  logic [NF-1:0] status_q;
  logic [NF-1:0] mask_q;
  logic [NF-1:0] qual_w;
  logic [NF-1:0] qual_prev_q;
  logic irq_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [NVM_DW-1:0] nvm_rdata;
  logic [NVM_DW-1:0] ctrl1_w;
  logic [NVM_DW-1:0] cal_w;
  logic [31:0] ram_q [RAM_DEPTH];
  logic output_mode_bit2;
  logic output_mode_bit1;
  logic output_mode_bit0;
  logic [MODE_W-1:0] mode_w;
  logic analog_w;
  logic digital_w;
  logic [CNT_W-1:0] cnt_thr_w;
  logic [ANGLE_W-1:0] angle_cal_w;
  logic latch_set_w;
  logic hiz_latch_q;
  logic hiz_now_w;
  logic diag_w;
  logic [1:0] code_w;
  logic [ANGLE_W-1:0] ang_tx_w;
  logic [ANGLE_W-1:0] lvl_b_w;
  logic [SW_W-1:0] serial_word_q;
  logic error_flag_q;
  logic [ANGLE_W-1:0] out_a_q;
  logic out_a_oe_n_q;
  logic [ANGLE_W-1:0] out_b_q;
  logic out_b_oe_n_q;

  // ==========================================================
  // ahb-lite slave: writes take no wait state, reads take one
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_en = (bus_st_q == BUS_WR);
  assign wr_reg = dor_region(addr_q);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_st_q <= BUS_IDLE;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      case (bus_st_q)
        BUS_RD:
        begin
          // the wait state lets a write just before land first
          hrdata_q <= rd_mux;
          hreadyout_q <= 1'b1;
          bus_st_q <= BUS_IDLE;
        end
        default:
        begin
          if (addr_ok)
          begin
            bus_st_q <= hwrite ? BUS_WR : BUS_RD;
            addr_q <= haddr[7:0];
            hreadyout_q <= hwrite;
          end
          else
          begin
            bus_st_q <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wr_reg)
      REG_STATUS: rd_mux[NF-1:0] = status_q;
      REG_MASK: rd_mux[NF-1:0] = mask_q;
      REG_STATE: rd_mux = {13'h0000, hiz_now_w, hiz_latch_q, error_flag_q, 2'h0, serial_word_q};
      REG_NVM: rd_mux[NVM_DW-1:0] = nvm_rdata;
      REG_RAM: rd_mux = ram_q[addr_q[MEM_IW+1:2]];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  // ==========================================================
  // nonvolatile image and working ram
  dor_nvm #(.DEPTH(NVM_DEPTH), .DW(NVM_DW)) u_nvm
  (
    .clk(clk),
    .arst_n(arst_n),
    .we(wr_en && (wr_reg == REG_NVM)),
    .widx(addr_q[MEM_IW+1:2]),
    .wdata(hwdata[NVM_DW-1:0]),
    .ridx(addr_q[MEM_IW+1:2]),
    .rdata(nvm_rdata),
    .ctrl1(ctrl1_w),
    .cal(cal_w)
  );

  // words 0 and 1 belong to hardware; a software write there is overwritten each tick
  // scratch writes must not be lost when they meet a tick, so the tick only wins on 0 and 1
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < RAM_DEPTH; i++) ram_q[i] <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en && (wr_reg == REG_RAM)) ram_q[addr_q[MEM_IW+1:2]] <= hwdata;
      if (tick_q)
      begin
        ram_q[0] <= {19'h00000, angle_cal_w};
        ram_q[1] <= {23'h000000, qual_w};
      end
    end
  end

  // ==========================================================
  // mode decode and fault qualification
  assign mode_w = ctrl1_w[MODE_LSB +: MODE_W];
  assign output_mode_bit2 = mode_w[2];
  assign output_mode_bit1 = mode_w[1];
  assign output_mode_bit0 = mode_w[0];
  assign analog_w = output_mode_bit2;
  assign digital_w = !output_mode_bit2 && !output_mode_bit1;
  assign cnt_thr_w = ctrl1_w[CNT_LSB +: CNT_W];
  // the offset wraps around the full turn, so the carry is dropped on purpose
  assign angle_cal_w = ANGLE_W'(angle_in + cal_w[ANGLE_W-1:0]);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == TICK_W'(SAMPLE_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == TICK_W'(SAMPLE_CYC - 1)) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  for (genvar i = 0; i < NF; i++)
  begin : g_qual
    dor_qual #(.CW(CNT_W)) u_qual
    (
      .clk(clk),
      .arst_n(arst_n),
      .tick(tick_q),
      .det(fault_det[i]),
      .thr(cnt_thr_w),
      .qual_q(qual_w[i])
    );
  end

  // ==========================================================
  // fault response
  assign latch_set_w = analog_w ? |(qual_w & LATCH_ANA_MASK) : |(qual_w & LATCH_DIG_MASK);
  // reserved modes 010 and 011 keep both pins released
  assign hiz_now_w = hiz_latch_q || latch_set_w || (!analog_w && !digital_w) ||
                     (analog_w ? |(qual_w & HIZ_ANA_MASK) : |(qual_w & HIZ_DIG_MASK));
  assign diag_w = digital_w && |(qual_w & DIAG_DIG_MASK);

  // only one code fits; the checksum outranks the input stage, the warning ranks last
  always_comb
  begin
    code_w = CODE_OTW;
    if (qual_w[F_CRC]) code_w = CODE_CRC;
    else if (qual_w[F_INSTG]) code_w = CODE_INSTG;
  end

  always_comb
  begin
    ang_tx_w = (mode_w == MODE_CPL) ? ~angle_cal_w : angle_cal_w;
    if (diag_w) ang_tx_w[1:0] = code_w;
  end

  always_comb
  begin
    case (mode_w)
      MODE_INV: lvl_b_w = ~angle_cal_w;
      MODE_HALF: lvl_b_w = angle_cal_w >> 1;
      MODE_CMP: lvl_b_w = (angle_cal_w >= CMP_THRESH) ? '1 : '0;
      default: lvl_b_w = '0;
    endcase
  end

  // only power-on reset clears the latch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) hiz_latch_q <= 1'b0;
    else if (latch_set_w) hiz_latch_q <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      serial_word_q <= '0;
      error_flag_q <= 1'b0;
      out_a_q <= '0;
      out_a_oe_n_q <= 1'b1;
      out_b_q <= '0;
      out_b_oe_n_q <= 1'b1;
    end
    else
    begin
      serial_word_q <= {diag_w, ang_tx_w};
      error_flag_q <= diag_w;
      out_a_q <= angle_cal_w;
      out_a_oe_n_q <= hiz_now_w;
      out_b_q <= lvl_b_w;
      // in serial modes pin b is the clock input and is never driven
      out_b_oe_n_q <= hiz_now_w || !analog_w || (mode_w == MODE_OFF);
    end
  end

  assign serial_word = serial_word_q;
  assign error_flag = error_flag_q;
  assign data_or_analog_out_a = out_a_q;
  assign data_or_analog_out_a_oe_n = out_a_oe_n_q;
  assign clock_or_analog_out_b = out_b_q;
  assign clock_or_analog_out_b_oe_n = out_b_oe_n_q;

  // ==========================================================
  // interrupt status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q <= '0;
      mask_q <= MASK_RST;
      qual_prev_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      qual_prev_q <= qual_w;
      status_q <= (status_q & ~((wr_en && wr_reg == REG_STATUS) ? hwdata[NF-1:0] : '0))
                  | (qual_w & ~qual_prev_q);
      if (wr_en && wr_reg == REG_MASK) mask_q <= hwdata[NF-1:0];
      irq_q <= |(status_q & mask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  latch_hold_a: assert property (hiz_latch_q |=> hiz_latch_q && out_a_oe_n_q)
    else $error("released pins returned without reset");
  analog_release_a: assert property (analog_w && (qual_w & HIZ_ANA_MASK) != '0
    |=> out_a_oe_n_q && out_b_oe_n_q)
    else $error("analog fault left a pin driven");
  digital_flag_a: assert property (diag_w |=> serial_word_q[SW_ERR] && error_flag_q)
    else $error("digital fault without error flag");
  fault_code_a: assert property (digital_w && qual_w[F_CRC] |=> serial_word_q[1:0] == CODE_CRC)
    else $error("wrong fault code in serial word");
  upper_angle_a: assert property (diag_w && mode_w == MODE_STD
    |=> serial_word_q[ANGLE_W-1:2] == $past(angle_cal_w[ANGLE_W-1:2]))
    else $error("upper angle bits lost under error flag");
  instage_recover_a: assert property (digital_w && !hiz_latch_q && qual_w == (NF'(1) << F_INSTG)
    |=> !hiz_latch_q && !out_a_oe_n_q)
    else $error("input stage fault latched in digital mode");
  warn_analog_a: assert property (analog_w && !hiz_latch_q && qual_w == (NF'(1) << F_OTW)
    |=> !out_a_oe_n_q && !error_flag_q)
    else $error("temperature warning acted in analog mode");
  qual_tick_a: assert property ($rose(qual_w[F_INSTG]) |-> $past(tick_q) && $past(fault_det[F_INSTG]))
    else $error("fault qualified off the sample tick");
  mode_load_a: assert property (wr_en && wr_reg == REG_NVM && addr_q[MEM_IW+1:2] == '0
    |=> mode_w == $past(hwdata[MODE_LSB +: MODE_W]))
    else $error("control word write not applied to mode");
  cal_path_a: assert property (tick_q |=> ram_q[0][ANGLE_W-1:0] == $past(angle_cal_w))
    else $error("working ram missed the calibrated angle");
  irq_level_a: assert property ((status_q & mask_q) != '0 |=> irq_q)
    else $error("unmasked status without interrupt");

  latch_seen_c: cover property ($rose(hiz_latch_q));
  flag_seen_c: cover property (diag_w ##1 !diag_w);
  read_seen_c: cover property (bus_st_q == BUS_RD ##1 hreadyout_q);
endmodule : dor_top

/* File: sim/dor_host_model.sv */
/*
  Host side model: resolves the two output pins as an external reader sees them.
  Assumes pull-up resistors on both pins, so a released pin reads as all ones.
*/
module dor_host_model
  import dor_pkg::*;
(
  // levels and enables from the device
  input wire logic [ANGLE_W-1:0] lvl_a,
  input wire logic oe_n_a,
  input wire logic [ANGLE_W-1:0] lvl_b,
  input wire logic oe_n_b,
  // levels seen by the host
  output logic [ANGLE_W-1:0] pin_a,
  output logic [ANGLE_W-1:0] pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pin resolution
  // a released pin never shows the last level; the pull-up wins
  assign pin_a = oe_n_a ? {ANGLE_W{1'b1}} : lvl_a;
  assign pin_b = oe_n_b ? {ANGLE_W{1'b1}} : lvl_b;
endmodule : dor_host_model

/* File: sim/dor_top_tb_top.sv */
/*
  Self-checking bench of the diagnosis output response block.
  Assumes a single 100 MHz clock, one AHB-Lite slave and a 100-cycle fault sampling tick.
*/
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module dor_top_tb_top
  import dor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // constants and signals
  localparam logic [ANGLE_W-1:0] ANG = 13'h1abd;
  localparam logic [ANGLE_W-1:0] CMP = 13'h1000;
  localparam int TK = SAMPLE_CYC + 5;
  localparam int TIMEOUT = 20000;
  localparam logic [NF-1:0] FV [4] = '{9'h02c, 9'h028, 9'h020, 9'h008};
  localparam logic [1:0] FC [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
  localparam logic [NF-1:0] LF [8] = '{9'h001, 9'h002, 9'h004, 9'h010, 9'h040, 9'h001,
                                       9'h002, 9'h040};
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, error_flag, irq, oe_a, oe_b;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [NF-1:0] fault_det;
  logic [ANGLE_W-1:0] angle_in, lvl_a, lvl_b, pin_a, pin_b;
  logic [SW_W-1:0] serial_word;
  int failures, total_checks, cycles;

  dor_top #(.CMP_THRESH(CMP)) i_dor_top (.clk(clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fault_det(fault_det), .angle_in(angle_in), .serial_word(serial_word),
    .error_flag(error_flag), .data_or_analog_out_a(lvl_a), .data_or_analog_out_a_oe_n(oe_a),
    .clock_or_analog_out_b(lvl_b), .clock_or_analog_out_b_oe_n(oe_b), .irq(irq));

  dor_host_model i_dor_host_model (.lvl_a(lvl_a), .oe_n_a(oe_a), .lvl_b(lvl_b),
    .oe_n_b(oe_b), .pin_a(pin_a), .pin_b(pin_b));

  // ==========================================================
  // clock, timeout and closing
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // limit is a little over twice the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == TIMEOUT)
    begin
      failures++;
      $display("timeout after %0d cycles", cycles);
      wrap_up();
    end
  end

  // ==========================================================
  // bus and stimulus tasks, all entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic hold(input logic [NF-1:0] f, input int cyc);
    fault_det <= f;
    repeat (cyc) @(posedge clk);
  endtask : hold

  task automatic set_cfg(input logic [2:0] m, input logic [2:0] cnt, input logic [12:0] ofs);
    logic [31:0] d;
    ahb(1'b1, OFS_NVM_BASE, {25'h0, cnt, 1'b0, m}, d);
    ahb(1'b1, OFS_NVM_BASE + 8'h04, {19'h0, ofs}, d);
    repeat (TK) @(posedge clk);
  endtask : set_cfg

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic test_end(input string n);
    $display("test %s done: checks %0d failures %0d", n, total_checks, failures);
  endtask : test_end

  function automatic logic [SW_W-1:0] exp_sw(input logic flag, input logic cpl,
                                             input logic [1:0] code, input logic [12:0] ang);
    logic [ANGLE_W-1:0] a;
    a = cpl ? ~ang : ang;
    return flag ? {1'b1, a[12:2], code} : {1'b0, a};
  endfunction : exp_sw

  function automatic logic [ANGLE_W-1:0] exp_b(input logic [2:0] m);
    case (m)
      3'h4: return ~ANG;
      3'h5: return ANG >> 1;
      3'h6: return (ANG >= CMP) ? {ANGLE_W{1'b1}} : {ANGLE_W{1'b0}};
      default: return {ANGLE_W{1'b0}};
    endcase
  endfunction : exp_b

  // ==========================================================
  // test sequence
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    fault_det = '0;
    angle_in = ANG;
    arst_n = 1'b0;
    do_reset();
    repeat (TK) @(posedge clk);
    `CHK(oe_a, 1'b0)
    `CHK(oe_b, 1'b1)
    `CHK(serial_word, exp_sw(1'b0, 1'b0, 2'h0, ANG))
    ahb(1'b0, OFS_STATUS, 32'h0, v);
    `CHK(v, 32'h0)
    `CHK(hresp, 1'b0)
    ahb(1'b0, OFS_MASK, 32'h0, v);
    `CHK(v, 32'h0)
    ahb(1'b1, 8'h10, 32'hffff_ffff, v);
    ahb(1'b0, 8'h10, 32'h0, v);
    `CHK(v, 32'h0)
    ahb(1'b1, OFS_RAM_BASE + 8'h08, 32'h1234_5678, v);
    ahb(1'b0, OFS_RAM_BASE + 8'h08, 32'h0, v);
    `CHK(v, 32'h1234_5678)
    set_cfg(3'h0, 3'h0, 13'h0003);
    `CHK(serial_word, exp_sw(1'b0, 1'b0, 2'h0, ANG + 13'h0003))
    ahb(1'b0, OFS_RAM_BASE, 32'h0, v);
    `CHK(v, {19'h0, ANG + 13'h0003})
    test_end("reset_and_map");

    for (int m = 0; m < 2; m++)
    begin
      set_cfg(m[2:0], 3'h0, 13'h0);
      for (int i = 0; i < 4; i++)
      begin
        hold(FV[i], TK);
        `CHK(error_flag, 1'b1)
        `CHK(serial_word, exp_sw(1'b1, m[0], FC[i], ANG))
        `CHK(oe_a, 1'b0)
        hold('0, TK);
        `CHK(error_flag, 1'b0)
      end
      hold(9'h010, TK);
      `CHK(error_flag, 1'b0)
      `CHK(oe_a, 1'b0)
      hold('0, TK);
    end
    test_end("digital_codes");

    set_cfg(3'h0, 3'h3, 13'h0);
    // events of the previous test are still sticky; clear them before unmasking
    ahb(1'b1, OFS_STATUS, 32'h1ff, v);
    ahb(1'b1, OFS_MASK, 32'h8, v);
    // two ticks at most inside 190 cycles, one short of the count
    hold(9'h008, 190);
    hold('0, TK);
    `CHK(error_flag, 1'b0)
    `CHK(irq, 1'b0)
    hold(9'h008, 400);
    `CHK(error_flag, 1'b1)
    `CHK(irq, 1'b1)
    hold('0, TK);
    `CHK(error_flag, 1'b0)
    ahb(1'b0, OFS_STATUS, 32'h0, v);
    `CHK(v, 32'h8)
    `CHK(irq, 1'b1)
    ahb(1'b1, OFS_STATUS, 32'h8, v);
    ahb(1'b0, OFS_STATUS, 32'h0, v);
    `CHK(v, 32'h0)
    `CHK(irq, 1'b0)
    set_cfg(3'h0, 3'h0, 13'h0);
    hold(9'h020, TK);
    hold('0, TK);
    ahb(1'b0, OFS_STATUS, 32'h0, v);
    `CHK(v, 32'h20)
    `CHK(irq, 1'b0)
    ahb(1'b1, OFS_STATUS, 32'h20, v);
    test_end("count_and_irq");

    for (int m = 4; m < 8; m++)
    begin
      set_cfg(m[2:0], 3'h0, 13'h0);
      `CHK(pin_a, ANG)
      `CHK(oe_b, (m == 7))
      if (m != 7)
        `CHK(pin_b, exp_b(m[2:0]))
      hold(9'h008, TK);
      `CHK(pin_a, {ANGLE_W{1'b1}})
      `CHK(oe_b, 1'b1)
      `CHK(error_flag, 1'b0)
      hold(9'h020, TK);
      `CHK(oe_a, 1'b0)
      `CHK(error_flag, 1'b0)
      hold('0, TK);
    end
    set_cfg(3'h2, 3'h0, 13'h0);
    `CHK(oe_a, 1'b1)
    `CHK(oe_b, 1'b1)
    test_end("analog_modes");

    // the first five faults are tried in analog mode, the rest in serial mode
    for (int i = 0; i < 8; i++)
    begin
      if (i < 5)
        set_cfg(3'h4, 3'h0, 13'h0);
      hold(LF[i], TK);
      hold('0, TK);
      `CHK(oe_a, 1'b1)
      ahb(1'b0, OFS_STATE, 32'h0, v);
      `CHK(v[17], 1'b1)
      do_reset();
      repeat (TK) @(posedge clk);
      `CHK(oe_a, 1'b0)
    end
    test_end("latched_faults");
    wrap_up();
  end
endmodule : dor_top_tb_top
